/* File: core/hrep_top.v */
// Notes on behaviour
// - coarse edge delayed by fine duty or fine phase steps
// - 255 fine positions inside one clock
// - only channel a is delayed, b untouched
// - fine byte sits below 16-bit coarse value
// - fine phase byte written directly, unshadowed
// - fine duty byte has shadow and active copy
// - configuration holds edge, source, shadow selections
// - edge mode: off, rising, falling or both
// - source: fine duty or fine phase
// - shadow setting affects fine duty only
// - self-check measures steps per clock period
// - only upper byte of duty word counts
// - coarse timing runs on the system clock
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "hrep_map.vh"

module hrep_top (
  input  wire        MCLK_I,
  input  wire        RESET_N_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  input  wire [3:0]  PSTRB_I,
  output wire [31:0] PRDATA_O,
  output wire        PREADY_O,
  output wire        PSLVERR_O,
  input  wire        COARSE_A_I,
  input  wire        COARSE_B_I,
  input  wire        SHADOW_LOAD_I,
  input  wire [15:0] COARSE_DUTY_I,
  input  wire [15:0] COARSE_PHASE_I,
  input  wire        CAL_LATE_I,
  output wire        PWM_A_O,
  output wire        PWM_B_O,
  output wire        STEP_EDGE_O,
  output wire [7:0]  STEP_COUNT_O,
  output wire [7:0]  CAL_TAP_O,
  output wire        CAL_RUN_O
);

  // bus answer flops
  reg  [31:0] prdata_reg;
  reg  [31:0] prdata_next;
  reg         pready_reg;
  reg         pslverr_reg;

  // software-visible state
  reg  [7:0]  phase_ext_reg;
  reg  [7:0]  phase_ext_next;
  reg  [7:0]  duty_shadow_reg;
  reg  [7:0]  duty_shadow_next;
  reg  [7:0]  duty_active_reg;
  reg  [7:0]  duty_active_next;
  reg  [3:0]  config_reg;
  reg  [3:0]  config_next;
  reg         cal_done_reg;
  reg         cal_done_next;
  reg         cal_start_reg;
  reg         cal_start_next;

  // decode
  wire [7:0]  idx;
  wire        addr_ok;
  reg         hit_phase;
  reg         hit_duty;
  reg         hit_cfg;
  reg         hit_dfull;
  reg         hit_pfull;
  reg         hit_cal;
  reg         hit_stat;
  wire        mapped;
  wire        setup;
  wire        wr_en;
  reg         wr_phase;
  reg         wr_duty;
  reg         wr_cfg;
  reg         wr_cal;

  // datapath
  wire [1:0]  edge_mode;
  wire        src_sel;
  wire        shdw_mode;
  wire [7:0]  duty_wdata;
  wire [7:0]  steps;
  wire [23:0] duty_full;
  wire [23:0] phase_full;
  wire        shadow_pend;
  wire        cal_busy;
  wire        cal_done_pulse;
  wire [7:0]  cal_result;

  // index decode; only aligned words inside the window answer
  assign idx       = PADDR_I[`HREP_IDX_MSB:`HREP_IDX_LSB];
  assign addr_ok   = (PADDR_I[`HREP_ADDR_MSB:`HREP_ADDR_HI_LSB] == `HREP_ADDR_HI_ZERO) &&
                     (PADDR_I[`HREP_ALIGN_MSB:`HREP_ALIGN_LSB] == `HREP_ALIGN_ZERO);
  assign mapped    = hit_phase | hit_duty | hit_cfg | hit_dfull |
                     hit_pfull | hit_cal | hit_stat;

  // register select; at most one hit per access
  always @* begin
    hit_phase = 1'b0;
    hit_duty  = 1'b0;
    hit_cfg   = 1'b0;
    hit_dfull = 1'b0;
    hit_pfull = 1'b0;
    hit_cal   = 1'b0;
    hit_stat  = 1'b0;
    if (addr_ok && (idx == `HREP_IDX_PHASE_EXT)) begin
      hit_phase = 1'b1;
    end else if (addr_ok && (idx == `HREP_IDX_DUTY_EXT)) begin
      hit_duty = 1'b1;
    end else if (addr_ok && (idx == `HREP_IDX_CONFIG)) begin
      hit_cfg = 1'b1;
    end else if (addr_ok && (idx == `HREP_IDX_DUTY_FULL)) begin
      hit_dfull = 1'b1;
    end else if (addr_ok && (idx == `HREP_IDX_PHASE_FULL)) begin
      hit_pfull = 1'b1;
    end else if (addr_ok && (idx == `HREP_IDX_CAL)) begin
      hit_cal = 1'b1;
    end else if (addr_ok && (idx == `HREP_IDX_STATUS)) begin
      hit_stat = 1'b1;
    end
  end

  // apb phases; a write lands at the edge that completes the access
  assign setup    = PSEL_I & ~PENABLE_I;
  assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I & pready_reg;

  // write strobes; a lane strobe of zero leaves the register alone
  always @* begin
    wr_phase = 1'b0;
    wr_duty  = 1'b0;
    wr_cfg   = 1'b0;
    wr_cal   = 1'b0;
    if (wr_en && hit_phase) begin
      wr_phase = PSTRB_I[`HREP_LANE0];
    end else if (wr_en && hit_duty) begin
      wr_duty = PSTRB_I[`HREP_LANE1];
    end else if (wr_en && hit_cfg) begin
      wr_cfg = PSTRB_I[`HREP_LANE0];
    end else if (wr_en && hit_cal) begin
      wr_cal = PSTRB_I[`HREP_LANE0];
    end
  end

  // configuration fields
  assign edge_mode = config_reg[`HREP_CFG_EDGE_MSB:`HREP_CFG_EDGE_LSB];
  assign src_sel   = config_reg[`HREP_CFG_SRC_BIT];
  assign shdw_mode = config_reg[`HREP_CFG_SHDW_BIT];

  // low byte of the duty word is dropped in hardware
  assign duty_wdata = PWDATA_I[`HREP_DUTY_STEP_MSB:`HREP_DUTY_STEP_LSB];

  // step source: duty extension or phase extension
  assign steps = (src_sel == `HREP_SRC_PHASE) ? phase_ext_reg
                                              : duty_active_reg;

  // combined coarse:fine words for read-back
  assign duty_full   = {COARSE_DUTY_I, duty_active_reg};
  assign phase_full  = {COARSE_PHASE_I, phase_ext_reg};
  assign shadow_pend = (duty_shadow_reg != duty_active_reg);

  // active duty copy: loaded on the coarse load strobe or immediately
  always @* begin
    duty_active_next = duty_active_reg;
    if (shdw_mode == `HREP_SHDW_IMMED) begin
      duty_active_next = wr_duty ? duty_wdata : duty_shadow_reg;
    end else if (SHADOW_LOAD_I) begin
      duty_active_next = duty_shadow_reg;
    end
  end

  // next values of the software registers
  always @* begin
    phase_ext_next   = phase_ext_reg;
    duty_shadow_next = duty_shadow_reg;
    config_next      = config_reg;
    if (wr_phase) begin
      phase_ext_next = PWDATA_I[`HREP_BYTE_MSB:`HREP_BYTE_LSB];  // no shadow
    end
    if (wr_duty) begin
      duty_shadow_next = duty_wdata;
    end
    if (wr_cfg) begin
      config_next = PWDATA_I[`HREP_CFG_MSB:`HREP_CFG_LSB];
    end
  end

  // register writes
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      phase_ext_reg   <= `HREP_STEP_ZERO;
      duty_shadow_reg <= `HREP_STEP_ZERO;
      duty_active_reg <= `HREP_STEP_ZERO;
      config_reg      <= `HREP_CFG_RST;
    end else begin
      phase_ext_reg   <= phase_ext_next;
      duty_shadow_reg <= duty_shadow_next;
      duty_active_reg <= duty_active_next;
      config_reg      <= config_next;
    end
  end

  // self-check start pulse and sticky done flag; a new done beats a clear
  always @* begin
    cal_start_next = wr_cal & PWDATA_I[`HREP_CAL_START_BIT] & ~cal_busy;
    cal_done_next  = cal_done_reg;
    if (wr_cal & PWDATA_I[`HREP_CAL_DONE_BIT]) begin
      cal_done_next = 1'b0;  // write one to clear
    end
    if (cal_done_pulse) begin
      cal_done_next = 1'b1;  // set wins over a same-cycle clear
    end
  end

  // self-check flops
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cal_start_reg <= 1'b0;
      cal_done_reg  <= 1'b0;
    end else begin
      cal_start_reg <= cal_start_next;
      cal_done_reg  <= cal_done_next;
    end
  end

  // read mux; reserved and unmapped bits read zero
  always @* begin
    prdata_next = `HREP_DATA_ZERO;
    if (hit_phase) begin
      prdata_next[`HREP_BYTE_MSB:`HREP_BYTE_LSB] = phase_ext_reg;
    end else if (hit_duty) begin
      prdata_next[`HREP_DUTY_STEP_MSB:`HREP_DUTY_STEP_LSB] = duty_shadow_reg;
    end else if (hit_cfg) begin
      prdata_next[`HREP_CFG_MSB:`HREP_CFG_LSB] = config_reg;
    end else if (hit_dfull) begin
      prdata_next[`HREP_FULL_MSB:`HREP_FULL_LSB] = duty_full;
    end else if (hit_pfull) begin
      prdata_next[`HREP_FULL_MSB:`HREP_FULL_LSB] = phase_full;
    end else if (hit_cal) begin
      prdata_next[`HREP_CAL_BUSY_BIT] = cal_busy;
      prdata_next[`HREP_CAL_DONE_BIT] = cal_done_reg;
      prdata_next[`HREP_CAL_RES_MSB:`HREP_CAL_RES_LSB] = cal_result;
    end else if (hit_stat) begin
      prdata_next[`HREP_BYTE_MSB:`HREP_BYTE_LSB] = steps;
      prdata_next[`HREP_STAT_PEND_BIT] = shadow_pend;
      prdata_next[`HREP_STAT_SRC_BIT]  = src_sel;
    end
  end

  // bus answer: data and ready raised after the setup edge, held one cycle
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      prdata_reg  <= `HREP_DATA_ZERO;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        prdata_reg  <= PWRITE_I ? `HREP_DATA_ZERO : prdata_next;
        pslverr_reg <= ~mapped;
      end else begin
        prdata_reg  <= `HREP_DATA_ZERO;
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign PRDATA_O  = prdata_reg;
  assign PREADY_O  = pready_reg;
  assign PSLVERR_O = pslverr_reg;

  // edge placement after the qualifier output, on the system clock
  hrep_edge_sel u_edge (
    .clk_i       (MCLK_I),
    .rst_n_i     (RESET_N_I),
    .coarse_a_i  (COARSE_A_I),
    .coarse_b_i  (COARSE_B_I),
    .edge_mode_i (edge_mode),
    .steps_i     (steps),
    .a_o         (PWM_A_O),
    .b_o         (PWM_B_O),
    .edge_o      (STEP_EDGE_O),
    .steps_o     (STEP_COUNT_O)
  );

  // self-check sweep of the calibration taps, 1 to 255
  hrep_cal u_cal (
    .clk_i    (MCLK_I),
    .rst_n_i  (RESET_N_I),
    .start_i  (cal_start_reg),
    .late_i   (CAL_LATE_I),
    .busy_o   (cal_busy),
    .done_o   (cal_done_pulse),
    .result_o (cal_result),
    .tap_o    (CAL_TAP_O)
  );

  assign CAL_RUN_O = cal_busy;

endmodule

/* File: core/hrep_map.vh */
`ifndef HREP_MAP_VH
`define HREP_MAP_VH

// apb address layout: byte address is four times the register index
`define HREP_ADDR_MSB       11
`define HREP_ADDR_HI_LSB    10
`define HREP_IDX_MSB        9
`define HREP_IDX_LSB        2
`define HREP_ALIGN_MSB      1
`define HREP_ALIGN_LSB      0
`define HREP_ADDR_HI_ZERO   2'h0
`define HREP_ALIGN_ZERO     2'h0

// register indices
`define HREP_IDX_PHASE_EXT  8'h02
`define HREP_IDX_DUTY_EXT   8'h08
`define HREP_IDX_CONFIG     8'h20
`define HREP_IDX_DUTY_FULL  8'h24
`define HREP_IDX_PHASE_FULL 8'h25
`define HREP_IDX_CAL        8'h28
`define HREP_IDX_STATUS     8'h29

// byte lanes
`define HREP_LANE0          0
`define HREP_LANE1          1

// fine duty word: step count is the upper byte
`define HREP_DUTY_STEP_MSB  15
`define HREP_DUTY_STEP_LSB  8
`define HREP_BYTE_MSB       7
`define HREP_BYTE_LSB       0

// configuration fields
`define HREP_CFG_EDGE_MSB   1
`define HREP_CFG_EDGE_LSB   0
`define HREP_CFG_SRC_BIT    2
`define HREP_CFG_SHDW_BIT   3
`define HREP_CFG_MSB        3
`define HREP_CFG_LSB        0
`define HREP_FULL_MSB       23
`define HREP_FULL_LSB       0
`define HREP_EDGE_OFF       2'h0
`define HREP_EDGE_RISE      2'h1
`define HREP_EDGE_FALL      2'h2
`define HREP_EDGE_BOTH      2'h3
`define HREP_SRC_DUTY       1'b0
`define HREP_SRC_PHASE      1'b1
`define HREP_SHDW_LOADED    1'b0
`define HREP_SHDW_IMMED     1'b1

// self-check control and status fields
`define HREP_CAL_START_BIT  0
`define HREP_CAL_BUSY_BIT   1
`define HREP_CAL_DONE_BIT   2
`define HREP_CAL_RES_MSB    15
`define HREP_CAL_RES_LSB    8
`define HREP_CAL_SETTLE     4'h4
`define HREP_CAL_CNT_ZERO   4'h0
`define HREP_CAL_CNT_ONE    4'h1

// status fields
`define HREP_STAT_PEND_BIT  8
`define HREP_STAT_SRC_BIT   9

// step counts and reset values
`define HREP_STEP_ZERO      8'h00
`define HREP_STEP_ONE       8'h01
`define HREP_STEP_MAX       8'hFF
`define HREP_CFG_RST        4'h0
`define HREP_DATA_ZERO      32'h0000_0000

`endif

/* File: core/hrep_edge_sel.v */
`timescale 1ns/1ps
`include "hrep_map.vh"

module hrep_edge_sel (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       coarse_a_i,
  input  wire       coarse_b_i,
  input  wire [1:0] edge_mode_i,
  input  wire [7:0] steps_i,
  output reg        a_o,
  output reg        b_o,
  output reg        edge_o,
  output reg  [7:0] steps_o
);

  reg        prev_reg;
  wire       rise;
  wire       fall;
  wire       sel;

  // coarse edge detection on the action-qualifier output of channel a
  assign rise = coarse_a_i & ~prev_reg;
  assign fall = ~coarse_a_i & prev_reg;
  // pick the edge that the delay line moves
  assign sel  = ((edge_mode_i == `HREP_EDGE_RISE) & rise) |
                ((edge_mode_i == `HREP_EDGE_FALL) & fall) |
                ((edge_mode_i == `HREP_EDGE_BOTH) & (rise | fall));

  // coarse level passes one flop; delay marker and count travel with the edge
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= 1'b0;
      a_o      <= 1'b0;
      b_o      <= 1'b0;
      edge_o   <= 1'b0;
      steps_o  <= `HREP_STEP_ZERO;
    end else begin
      prev_reg <= coarse_a_i;
      a_o      <= coarse_a_i;
      b_o      <= coarse_b_i;   // channel b is never delayed
      edge_o   <= sel & (steps_i != `HREP_STEP_ZERO);  // zero steps: coarse timing
      steps_o  <= sel ? steps_i : `HREP_STEP_ZERO;
    end
  end

endmodule

/* File: core/hrep_cal.v */
`timescale 1ns/1ps
`include "hrep_map.vh"

module hrep_cal (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       start_i,
  input  wire       late_i,
  output reg        busy_o,
  output reg        done_o,
  output reg  [7:0] result_o,
  output reg  [7:0] tap_o
);

  localparam ST_IDLE   = 2'b00;
  localparam ST_SETTLE = 2'b01;
  localparam ST_CHECK  = 2'b10;

  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [3:0] cnt_reg;
  reg  [3:0] cnt_next;
  reg  [7:0] tap_next;
  reg  [7:0] result_next;
  reg        busy_next;
  reg        done_next;
  reg        late_meta_reg;
  reg        late_sync_reg;

  // two-flop synchroniser for the delay line's late indication
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      late_meta_reg <= 1'b0;
      late_sync_reg <= 1'b0;
    end else begin
      late_meta_reg <= late_i;
      late_sync_reg <= late_meta_reg;
    end
  end

  // sweep taps until the delayed edge passes one clock period
  always @* begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    tap_next    = tap_o;
    result_next = result_o;
    busy_next   = busy_o;
    done_next   = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_i) begin
          tap_next   = `HREP_STEP_ONE;
          cnt_next   = `HREP_CAL_CNT_ZERO;
          busy_next  = 1'b1;
          state_next = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        cnt_next = cnt_reg + `HREP_CAL_CNT_ONE;
        if (cnt_reg == (`HREP_CAL_SETTLE - `HREP_CAL_CNT_ONE)) begin
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (late_sync_reg || (tap_o == `HREP_STEP_MAX)) begin
          result_next = tap_o;          // steps per coarse period
          done_next   = 1'b1;
          busy_next   = 1'b0;
          tap_next    = `HREP_STEP_ZERO;
          state_next  = ST_IDLE;
        end else begin
          tap_next   = tap_o + `HREP_STEP_ONE;
          cnt_next   = `HREP_CAL_CNT_ZERO;
          state_next = ST_SETTLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        busy_next  = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= `HREP_CAL_CNT_ZERO;
      tap_o     <= `HREP_STEP_ZERO;
      result_o  <= `HREP_STEP_ZERO;
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      tap_o     <= tap_next;
      result_o  <= result_next;
      busy_o    <= busy_next;
      done_o    <= done_next;
    end
  end

endmodule

/* File: bench/hrep_chk.sv */
`timescale 1ns/1ps
module hrep_chk (
  input wire        MCLK_I,
  input wire        RESET_N_I,
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PREADY_O,
  input wire        PSLVERR_O,
  input wire [31:0] PRDATA_O,
  input wire        COARSE_A_I,
  input wire        COARSE_B_I,
  input wire        PWM_A_O,
  input wire        PWM_B_O,
  input wire        STEP_EDGE_O,
  input wire [7:0]  STEP_COUNT_O,
  input wire [7:0]  CAL_TAP_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  // apb answer timing
  property p_rdy; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_one; PREADY_O |=> !PREADY_O; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err; PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_rdz; !PREADY_O |-> PRDATA_O == 32'h0000_0000; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside access");
  // channel paths
  property p_a; $past(RESET_N_I) |-> PWM_A_O == $past(COARSE_A_I); endproperty
  a_a: assert property (p_a) else $error("coarse a timing moved");
  property p_b; $past(RESET_N_I) |-> PWM_B_O == $past(COARSE_B_I); endproperty
  a_b: assert property (p_b) else $error("channel b altered");
  property p_step; STEP_EDGE_O |-> PWM_A_O != $past(PWM_A_O); endproperty
  a_step: assert property (p_step) else $error("step marker off edge");
  property p_cnt; STEP_EDGE_O == (STEP_COUNT_O != 8'h00); endproperty
  a_cnt: assert property (p_cnt) else $error("step count and marker disagree");
  property p_tap;
    $changed(CAL_TAP_O) |-> CAL_TAP_O == 8'h00 || CAL_TAP_O == $past(CAL_TAP_O) + 8'h01;
  endproperty
  a_tap: assert property (p_tap) else $error("tap skipped a step");
  // main scenarios seen
  c_step: cover property (STEP_EDGE_O && STEP_COUNT_O == 8'h5A);
  c_err: cover property (PSLVERR_O);
  c_cal: cover property ($changed(CAL_TAP_O) && CAL_TAP_O == 8'h00);
endmodule
bind hrep_top hrep_chk hrep_chk_i (.MCLK_I, .RESET_N_I, .PSEL_I, .PENABLE_I, .PREADY_O,
  .PSLVERR_O, .PRDATA_O, .COARSE_A_I, .COARSE_B_I, .PWM_A_O, .PWM_B_O, .STEP_EDGE_O,
  .STEP_COUNT_O, .CAL_TAP_O);

/* File: bench/hrep_dline.sv */
`timescale 1ns/1ps
module hrep_dline #(
  parameter [7:0] LATE_TAP = 8'h14
) (
  input  wire [7:0] tap_i,
  output wire       late_o
);
  // delayed edge passes a full period once the tap reaches the limit
  assign late_o = (tap_i >= LATE_TAP);
endmodule

/* File: bench/hrep_tb_top.sv */
`timescale 1ns/1ps
module hrep_tb_top;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  reg         psel = 1'b0;
  reg         pen = 1'b0;
  reg         pwr = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg         ca = 1'b0;
  reg         cb = 1'b0;
  reg         sld = 1'b0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        pa;
  wire        pb;
  wire        sedge;
  wire [7:0]  scnt;
  wire [7:0]  tap;
  wire        crun;
  wire        late;
  integer     error_cnt = 0;
  integer     n_compared = 0;
  reg  [31:0] rd;
  reg         er;
  // clock
  always #2.5 mclk = ~mclk;
  hrep_top hrep_top_i (.MCLK_I(mclk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .COARSE_A_I(ca), .COARSE_B_I(cb),
    .SHADOW_LOAD_I(sld), .COARSE_DUTY_I(16'h1234), .COARSE_PHASE_I(16'hA5C3),
    .CAL_LATE_I(late), .PWM_A_O(pa), .PWM_B_O(pb), .STEP_EDGE_O(sedge),
    .STEP_COUNT_O(scnt), .CAL_TAP_O(tap), .CAL_RUN_O(crun));
  hrep_dline #(.LATE_TAP(8'h14)) hrep_dline_i (.tap_i(tap), .late_o(late));
  task results;
    begin
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  // one apb transfer: access held until pready is sampled high at an edge
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      pen <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge mclk);
        n = n + 1;
      end
      chk(pready, 1, "pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task rdchk(input [11:0] a, input [31:0] exp, input string what);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp, what);
      chk(er, 0, "pslverr");
    end
  endtask
  // move both coarse inputs, judge the outputs one clock later
  task coarse_step(input va, input vb, input [7:0] exp);
    begin
      @(posedge mclk);
      ca <= va;
      cb <= vb;
      @(posedge mclk);
      #1;
      chk(pa, va, "pwm_a");
      chk(pb, vb, "pwm_b");
      chk(sedge, exp != 8'h00, "step_edge");
      chk(scnt, exp, "step_count");
    end
  endtask
  task wait_run(input v);
    integer n;
    begin
      n = 0;
      while (crun !== v && n < 2000) begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      chk(crun, v, "cal_run");
    end
  endtask
  task t_regs;
    begin
      rdchk(12'h080, 32'h0000_0000, "cfg_rst");
      apb(1'b1, 12'h080, 32'hFFFF_FFFF);
      rdchk(12'h080, 32'h0000_000F, "cfg_rw");
      apb(1'b1, 12'h008, 32'hFFFF_FF5A);
      rdchk(12'h008, 32'h0000_005A, "phase");
      rdchk(12'h094, 32'h00A5_C35A, "phase_full");
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(er, 1, "unmapped_err");
      chk(rd, 0, "unmapped_rd");
    end
  endtask
  task t_duty;
    begin
      // coarse inputs already set up; rise edge paired with duty source
      apb(1'b1, 12'h080, 32'h0000_0001);
      // twelve steps plus the rounding constant
      apb(1'b1, 12'h020, 32'h0000_0C80);
      rdchk(12'h020, 32'h0000_0C00, "duty_shadow");
      rdchk(12'h090, 32'h0012_3400, "duty_held");
      coarse_step(1'b1, 1'b0, 8'h00);
      coarse_step(1'b0, 1'b0, 8'h00);
      // load with the coarse compare load moment
      @(posedge mclk);
      sld <= 1'b1;
      @(posedge mclk);
      sld <= 1'b0;
      rdchk(12'h090, 32'h0012_340C, "duty_active");
      coarse_step(1'b1, 1'b1, 8'h0C);
      coarse_step(1'b0, 1'b0, 8'h00);
    end
  endtask
  task t_modes;
    integer m;
    reg [7:0] s;
    begin
      for (m = 0; m < 8; m = m + 1) begin
        apb(1'b1, 12'h080, m);
        s = m[2] ? 8'h5A : 8'h0C;
        coarse_step(1'b1, m[0], m[0] ? s : 8'h00);
        coarse_step(1'b0, 1'b0, m[1] ? s : 8'h00);
      end
    end
  endtask
  task t_immed;
    begin
      apb(1'b1, 12'h080, 32'h0000_0009);
      apb(1'b1, 12'h020, 32'h0000_0500);
      rdchk(12'h090, 32'h0012_3405, "duty_immed");
      apb(1'b1, 12'h080, 32'h0000_0007);
      apb(1'b1, 12'h008, 32'h0000_0033);
      coarse_step(1'b1, 1'b0, 8'h33);
      coarse_step(1'b0, 1'b0, 8'h33);
      rdchk(12'h0A4, 32'h0000_0233, "status");
    end
  endtask
  task t_cal;
    begin
      apb(1'b1, 12'h0A0, 32'h0000_0001);
      wait_run(1'b1);
      wait_run(1'b0);
      chk(tap, 0, "tap_idle");
      rdchk(12'h0A0, 32'h0000_1404, "cal_done");
      apb(1'b1, 12'h0A0, 32'h0000_0004);
      rdchk(12'h0A0, 32'h0000_1400, "cal_clear");
    end
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs;
    t_duty;
    t_modes;
    t_immed;
    t_cal;
    results;
  end
  // watchdog
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    results;
  end
endmodule
